/* File: dsf_defines.svh */
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

// Register indices; byte address is four times the index
`define DSF_IDX_STATE     10'h040
`define DSF_IDX_CURRENT   10'h05f
`define DSF_IDX_SPEED     10'h0a8
`define DSF_IDX_IO        10'h0d8
`define DSF_IDX_RPM       10'h0e0
`define DSF_IDX_AMPS      10'h0e1
`define DSF_IDX_CTRL      10'h0e2

// Field positions
`define DSF_ST_ENA        0
`define DSF_ST_OK         4
`define DSF_ST_STILL      9
`define DSF_ST_RDY        14
`define DSF_CTRL_SWEN     0

// Bus responses
`define DSF_RESP_OKAY     2'h0
`define DSF_RESP_SLVERR   2'h2

// Timing and scaling
`define DSF_CLK_KHZ       50000
`define DSF_BLINK_HALF_MS 250
`define DSF_STILL_PERMILLE 1
`define DSF_FULL_SCALE    32767
`define DSF_NMAX_RPM      3000
`define DSF_IMAX_DECIAMP  100

`endif

/* File: dsf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Configuration host: a register bus master with one write and one read task
module dsf_host_model (
  input  wire logic        aclk,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Quiet bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // Address and data offered together; each half dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_busy;
    logic w_busy;
    aw_busy = 1'b1;
    w_busy = 1'b1;
    {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata} <= {1'b1, a, 1'b1, d};
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1'b1;
    while (aw_busy || w_busy) begin
      @(posedge aclk);
      // Released lines show the inverse, so stale values cannot pass
      if (aw_busy && s_axi_awready) begin
        aw_busy = 1'b0;
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      end
      if (w_busy && s_axi_wready) begin
        w_busy = 1'b0;
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Spare edge so a following call never drives the same step
    @(posedge aclk);
  endtask
  // Read: hold the address until taken, then wait for the answer
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    {s_axi_arvalid, s_axi_araddr, s_axi_rready} <= {1'b1, a, 1'b1};
    do @(posedge aclk); while (!s_axi_arready);
    {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* File: dsf_pkg.sv */
`default_nettype none
package dsf_pkg;

  // Live drive conditions, most significant state bit first
  typedef struct packed {
    logic handwheel_selected;
    logic field_release_pulsed;
    logic peak_current_warning;
    logic analog_derate_possible;
    logic motor_temp_current_limit;
    logic low_freq_limit;
    logic stage_temp_current_reduced;
    logic stage_temp_derate_possible;
    logic speed_current_limit;
    logic actual_limit_reached;
    logic switch_limit_reached;
    logic nclip_neg;
    logic nclip_pos;
    logic nclip_general;
    logic speed_inverted;
    logic brake_released_motor_on;
    logic in_tolerance;
    logic homing_done;
    logic homing_in_progress;
    logic home_switch;
    logic speed_ctrl_ok;
    logic position_ctrl_ok;
    logic torque_speed_limited;
    logic cont_current_limit;
    logic limit_neg_tripped;
    logic limit_pos_tripped;
    logic speed_limit_zeroed;
  } dsf_cond_type;

  // Pin levels mirrored in the I/O word
  typedef struct packed {
    logic brake_excited;
    logic dout_four;
    logic dout_three;
    logic power_stage_go;
    logic ready_relay_output;
    logic dout_two;
    logic dout_one;
    logic field_release_input;
    logic hardware_release_input;
    logic din_one;
    logic din_two;
    logic limit_input_two;
    logic limit_input_one;
  } dsf_pins_type;

  // Indicator segments
  typedef struct packed {
    logic point;
    logic bottom;
    logic right;
    logic left;
  } dsf_seg_type;

endpackage
`default_nettype wire

/* File: dsf_status.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"

module dsf_status #(
  parameter int BLINK_HALF_CYCLES = `DSF_BLINK_HALF_MS * `DSF_CLK_KHZ,
  parameter int FULL_SCALE        = `DSF_FULL_SCALE,
  parameter int NMAX_RPM          = `DSF_NMAX_RPM,
  parameter int IMAX_DECIAMP      = `DSF_IMAX_DECIAMP
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Drive side
  input  wire dsf_pkg::dsf_cond_type cond,
  input  wire dsf_pkg::dsf_pins_type pins,
  input  wire logic                  ctrl_reset_event,
  input  wire logic                  ballast_on,
  input  wire logic signed [15:0]    speed_raw,
  input  wire logic [15:0]           current_raw,
  output dsf_pkg::dsf_seg_type       segments,
  output logic                       drive_enabled
);

  // Refuse settings the counters and scaling cannot hold
  if (BLINK_HALF_CYCLES < 2 || BLINK_HALF_CYCLES > 16777215) begin : g_chk_blink
    $error("BLINK_HALF_CYCLES out of range");
  end
  if (FULL_SCALE < 1000 || FULL_SCALE > 32767) begin : g_chk_scale
    $error("FULL_SCALE out of range");
  end
  if (NMAX_RPM < 1 || NMAX_RPM > 32767) begin : g_chk_rpm
    $error("NMAX_RPM out of range");
  end
  if (IMAX_DECIAMP < 1 || IMAX_DECIAMP > 32767) begin : g_chk_amps
    $error("IMAX_DECIAMP out of range");
  end

  // Standstill threshold: 0.1 percent of full scale
  localparam logic [16:0] STILL_LIMIT =
    17'((FULL_SCALE * `DSF_STILL_PERMILLE) / 1000);
  localparam logic [23:0] BLINK_LAST = 24'(BLINK_HALF_CYCLES - 1);
  localparam logic signed [16:0] NMAX_S = 17'(NMAX_RPM);
  localparam logic [15:0] IMAX_U = 16'(IMAX_DECIAMP);

  // Whole module state in one word
  typedef struct packed {
    logic [31:0] state_word;   // Live drive state
    logic [15:0] io_word;      // Live pin mirror
    logic [15:0] speed_val;    // Raw speed sample
    logic [15:0] current_val;  // Raw current sample
    logic [15:0] rpm_val;      // Speed scaled to rpm
    logic [15:0] amps_val;     // Current in 0.1 A
    logic        sw_enable;    // Software enable bit
    logic        drive_ok;     // Cleared by a bad reset
    logic [23:0] blink_cnt;    // Flash divider
    logic        blink;        // Flash phase
    dsf_pkg::dsf_seg_type seg; // Indicator drive
    logic        aw_done;      // Write address held
    logic        w_done;       // Write data held
    logic [11:0] aw_addr;      // Latched write address
    logic [31:0] w_data;       // Latched write data
    logic [3:0]  w_strb;       // Latched byte enables
    logic        bvalid;       // Write answer pending
    logic [1:0]  bresp;        // Write answer code
    logic        rvalid;       // Read answer pending
    logic [1:0]  rresp;        // Read answer code
    logic [31:0] rdata;        // Read answer data
  } dsf_state_type;

  dsf_state_type r;       // Registered state
  dsf_state_type next_r;  // Next state

  // Combinational helpers
  logic [16:0]        speed_mag;   // Magnitude of speed
  logic               standstill;  // Below threshold
  logic               run_and_sw;  // Both enables present
  logic signed [32:0] rpm_prod;    // Speed times rpm scale
  logic [31:0]        amp_prod;    // Current times amp scale
  logic [9:0]         wr_index;    // Decoded write index
  logic [9:0]         rd_index;    // Decoded read index
  logic               wr_fire;     // Both write halves held
  logic               rd_fire;     // Read address taken

  // Handshake outputs come straight from state
  assign s_axi_awready = !r.aw_done && !r.bvalid;
  assign s_axi_wready  = !r.w_done && !r.bvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rresp   = r.rresp;
  assign s_axi_rdata   = r.rdata;
  assign segments      = r.seg;
  assign drive_enabled = r.state_word[`DSF_ST_ENA];

  // Derived values feeding the next state
  always_comb begin
    // Magnitude; the negative extreme still fits in 17 bits
    speed_mag  = speed_raw[15] ? 17'(-{speed_raw[15], speed_raw})
                               : {1'b0, speed_raw};
    standstill = speed_mag < STILL_LIMIT;
    run_and_sw = pins.hardware_release_input && r.sw_enable;
    // Full scale maps to the nominal speed, shift keeps it cheap
    // Both operands widened first so the signed product is not cut short
    rpm_prod   = 33'(speed_raw) * 33'(NMAX_S);
    amp_prod   = current_raw * IMAX_U;
    wr_index   = r.aw_addr[11:2];
    rd_index   = s_axi_araddr[11:2];
    wr_fire    = r.aw_done && r.w_done && !r.bvalid;
    rd_fire    = s_axi_arvalid && !r.rvalid;
  end

  // Next state
  always_comb begin
    next_r = r;

    // Status words track live levels every cycle
    next_r.state_word = 32'h00000000;
    next_r.state_word[`DSF_ST_ENA]   = run_and_sw;
    next_r.state_word[1]  = cond.speed_limit_zeroed;
    next_r.state_word[2]  = cond.limit_pos_tripped;
    next_r.state_word[3]  = cond.limit_neg_tripped;
    next_r.state_word[`DSF_ST_OK]    = next_r.drive_ok;
    next_r.state_word[5]  = cond.cont_current_limit;
    next_r.state_word[6]  = cond.torque_speed_limited;
    next_r.state_word[7]  = cond.position_ctrl_ok;
    next_r.state_word[8]  = cond.speed_ctrl_ok;
    next_r.state_word[`DSF_ST_STILL] = standstill;
    next_r.state_word[10] = cond.home_switch;
    next_r.state_word[11] = cond.homing_in_progress;
    next_r.state_word[12] = cond.homing_done;
    next_r.state_word[13] = cond.in_tolerance;
    // Ready follows the relay contact itself, not a copy
    next_r.state_word[`DSF_ST_RDY]   = pins.ready_relay_output;
    next_r.state_word[15] = cond.brake_released_motor_on;
    next_r.state_word[16] = cond.speed_inverted;
    next_r.state_word[17] = cond.nclip_general;
    next_r.state_word[18] = cond.nclip_pos;
    next_r.state_word[19] = cond.nclip_neg;
    next_r.state_word[20] = cond.switch_limit_reached;
    next_r.state_word[21] = cond.actual_limit_reached;
    next_r.state_word[22] = cond.speed_current_limit;
    next_r.state_word[23] = cond.stage_temp_derate_possible;
    next_r.state_word[24] = cond.stage_temp_current_reduced;
    next_r.state_word[25] = cond.low_freq_limit;
    next_r.state_word[26] = cond.motor_temp_current_limit;
    next_r.state_word[27] = cond.analog_derate_possible;
    next_r.state_word[28] = cond.peak_current_warning;
    next_r.state_word[29] = cond.field_release_pulsed;
    // Bit 30 stays vacant and reads zero
    next_r.state_word[31] = cond.handwheel_selected;

    // I/O mirror; unused positions read zero
    next_r.io_word = 16'h0000;
    next_r.io_word[0]  = pins.limit_input_one;
    next_r.io_word[1]  = pins.limit_input_two;
    next_r.io_word[2]  = pins.din_two;
    next_r.io_word[3]  = pins.din_one;
    next_r.io_word[4]  = pins.hardware_release_input;
    next_r.io_word[5]  = pins.field_release_input;
    next_r.io_word[8]  = pins.dout_one;
    next_r.io_word[9]  = pins.dout_two;
    next_r.io_word[10] = pins.ready_relay_output;
    next_r.io_word[11] = pins.power_stage_go;
    next_r.io_word[12] = pins.dout_three;
    next_r.io_word[13] = pins.dout_four;
    next_r.io_word[15] = pins.brake_excited;

    // Drive-ok is sticky low until the next reset
    if (ctrl_reset_event) begin
      next_r.drive_ok = 1'b0;
    end

    // Measured values, raw and scaled
    next_r.speed_val   = speed_raw;
    next_r.rpm_val     = rpm_prod[30:15];
    next_r.current_val = current_raw;
    next_r.amps_val    = amp_prod[30:15];

    // Flash divider for the processor-active point
    if (r.blink_cnt == BLINK_LAST) begin
      next_r.blink_cnt = 24'h000000;
      next_r.blink     = !r.blink;
    end else begin
      next_r.blink_cnt = r.blink_cnt + 24'h000001;
    end

    // Indicator: point flashes, bottom lit while enabled
    next_r.seg.point  = r.blink;
    next_r.seg.bottom = run_and_sw;
    // Direction only while moving; ballast darkens it
    next_r.seg.right  = !standstill && !speed_raw[15] && !ballast_on;
    next_r.seg.left   = !standstill && speed_raw[15] && !ballast_on;

    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_done = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_done = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end

    // Both halves held: act and answer next cycle
    if (wr_fire) begin
      next_r.aw_done = 1'b0;
      next_r.w_done  = 1'b0;
      next_r.bvalid  = 1'b1;
      case (wr_index)
        `DSF_IDX_CTRL: begin
          // Software enable sits in the low byte
          if (r.w_strb[0]) begin
            next_r.sw_enable = r.w_data[`DSF_CTRL_SWEN];
          end
          next_r.bresp = `DSF_RESP_OKAY;
        end
        // Status words take no writes but answer normally
        `DSF_IDX_STATE, `DSF_IDX_CURRENT, `DSF_IDX_SPEED,
        `DSF_IDX_IO, `DSF_IDX_RPM, `DSF_IDX_AMPS: begin
          next_r.bresp = `DSF_RESP_OKAY;
        end
        default: begin
          next_r.bresp = `DSF_RESP_SLVERR;
        end
      endcase
    end else if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (rd_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = `DSF_RESP_OKAY;
      case (rd_index)
        `DSF_IDX_STATE: begin
          next_r.rdata = r.state_word;
        end
        `DSF_IDX_CURRENT: begin
          next_r.rdata = {16'h0000, r.current_val};
        end
        `DSF_IDX_SPEED: begin
          next_r.rdata = {16'h0000, r.speed_val};
        end
        `DSF_IDX_IO: begin
          next_r.rdata = {16'h0000, r.io_word};
        end
        `DSF_IDX_RPM: begin
          next_r.rdata = {16'h0000, r.rpm_val};
        end
        `DSF_IDX_AMPS: begin
          next_r.rdata = {16'h0000, r.amps_val};
        end
        `DSF_IDX_CTRL: begin
          next_r.rdata = {31'h00000000, r.sw_enable};
        end
        default: begin
          // Unmapped space answers with an error and zero data
          next_r.rdata = 32'h00000000;
          next_r.rresp = `DSF_RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r          <= '0;
      r.drive_ok <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

/* File: dsf_status_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the indicator outputs and the read channel of the status block
module dsf_status_assertions #(
  parameter int BLINK_HALF_CYCLES = 4
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire dsf_pkg::dsf_pins_type pins,
  input wire logic                  ballast_on,
  input wire logic signed [15:0]    speed_raw,
  input wire dsf_pkg::dsf_seg_type  segments,
  input wire logic                  drive_enabled
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Two cycles without the run pin must leave the drive disabled
  a_ena_needs_pin: assert property ((!pins.hardware_release_input)[*2] |=> !drive_enabled)
    else $error("drive enabled without run pin");
  // Bottom segment only lit behind a live run pin
  a_bottom_pin: assert property (segments.bottom |-> $past(pins.hardware_release_input))
    else $error("bottom segment lit without run pin");
  // Ballast darkens both direction segments
  a_ballast_dark: assert property ($past(ballast_on) |-> !segments.right && !segments.left)
    else $error("direction segment lit during ballast");
  // Right means forward, left means reverse
  a_right_sign: assert property (segments.right |-> !$past(speed_raw[15]))
    else $error("right segment lit on negative speed");
  a_left_sign: assert property (segments.left |-> $past(speed_raw[15]))
    else $error("left segment lit on positive speed");
  // Zero speed is standstill, so no direction is shown
  a_still_dark: assert property ($past(speed_raw) == 16'h0000 |-> segments[1:0] == 2'h0)
    else $error("direction segment lit at standstill");
  // Only the bench value of four is checked; other values need a counter
  a_point_blink: assert property (BLINK_HALF_CYCLES == 4 && $changed(segments.point)
    |=> $stable(segments.point)[*3] ##1 $changed(segments.point))
    else $error("point does not flash at the set rate");
  // Read answer comes the cycle after the address is taken
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule

bind dsf_status dsf_status_assertions #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES))
  dsf_status_assertions_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pins, .ballast_on, .speed_raw, .segments, .drive_enabled);
`default_nettype wire

/* File: dsf_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Status block driven through its register bus and live condition inputs
module dsf_status_tb_top;
  logic                  aclk, aresetn, ctrl_reset_event, ballast_on, drive_enabled, st;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic [11:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
  logic signed [15:0]    speed_raw;
  logic [15:0]           current_raw;
  dsf_pkg::dsf_cond_type cond;
  dsf_pkg::dsf_pins_type pins;
  dsf_pkg::dsf_seg_type  segments;
  int                    errors;
  int                    samples_checked;
  logic signed [15:0]    spd [4] = '{16'sd31, 16'sd32, -16'sd31, -16'sd32};
  // Short blink period keeps the flashing point visible in a short run
  dsf_status #(.BLINK_HALF_CYCLES(4)) dsf_status_i (.*);
  dsf_host_model dsf_host_model_i (.*);
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Status words lag the inputs, so let a few edges pass
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    dsf_host_model_i.rd(a, rdat, resp);
    chk($sformatf("rdata at %h", a), e, rdat);
    chk("rresp", 32'h0, {30'h0, resp});
  endtask
  // Enable, bottom, right, left sampled mid-cycle where they are settled
  task automatic outs(input logic [3:0] e);
    settle();
    @(negedge aclk);
    chk("enable and segments", {28'h0, e}, {28'h0, drive_enabled, segments[2:0]});
    @(posedge aclk);
  endtask
  function automatic logic [31:0] exp_st(input logic [26:0] c, input logic [12:0] p,
                                         input logic sw, input logic ok, input logic s);
    return {c[26], 1'b0, c[25:11], p[8], c[10:7], s, c[6:3], ok, c[2:0], p[4] & sw};
  endfunction
  function automatic logic [31:0] exp_io(input logic [12:0] p);
    return {16'h0, p[12], 1'b0, p[11:6], 2'h0, p[5:0]};
  endfunction
  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole sequence needs about four hundred cycles
  initial begin
    repeat (8000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
  initial begin
    {aresetn, ctrl_reset_event, ballast_on, speed_raw, current_raw} = '0;
    cond = '0;
    pins = '0;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(12'h100, exp_st('0, '0, 1'b0, 1'b1, 1'b1));
    // Walk a one across every condition, then every pin
    for (int i = 0; i < 27; i++) begin
      cond <= 27'h1 << i;
      settle();
      rdc(12'h100, exp_st(27'h1 << i, '0, 1'b0, 1'b1, 1'b1));
    end
    cond <= '0;
    for (int i = 0; i < 13; i++) begin
      pins <= 13'h1 << i;
      settle();
      rdc(12'h360, exp_io(13'h1 << i));
      rdc(12'h100, exp_st('0, 13'h1 << i, 1'b0, 1'b1, 1'b1));
    end
    // Software enable joins the run pin
    dsf_host_model_i.wr(12'h388, 32'h1, resp);
    pins <= 13'h010;
    speed_raw <= 16'sd100;
    outs(4'b1110);
    rdc(12'h100, exp_st('0, 13'h010, 1'b1, 1'b1, 1'b0));
    ballast_on <= 1'b1;
    outs(4'b1100);
    speed_raw <= -16'sd100;
    ballast_on <= 1'b0;
    outs(4'b1101);
    pins <= '0;
    outs(4'b0001);
    // Standstill threshold on both sides of zero
    foreach (spd[k]) begin
      speed_raw <= spd[k];
      st = (spd[k] < 32) && (spd[k] > -32);
      settle();
      rdc(12'h100, exp_st('0, '0, 1'b1, 1'b1, st));
      rdc(12'h2a0, {16'h0, spd[k]});
    end
    // Writes to status words are answered but change nothing
    current_raw <= 16'hbeef;
    dsf_host_model_i.wr(12'h17c, 32'h0, resp);
    chk("bresp", 32'h0, {30'h0, resp});
    dsf_host_model_i.wr(12'h100, 32'hffffffff, resp);
    rdc(12'h17c, 32'h0000beef);
    rdc(12'h100, exp_st('0, '0, 1'b1, 1'b1, 1'b0));
    // Scaled speed and current: half scale each way, full-scale current
    speed_raw <= 16'sh4000;
    current_raw <= 16'h8000;
    settle();
    rdc(12'h380, 32'h000005dc);
    speed_raw <= -16'sh4000;
    settle();
    rdc(12'h380, 32'h0000fa24);
    rdc(12'h384, 32'h00000064);
    rdc(12'h388, 32'h00000001);
    // Unmapped place
    dsf_host_model_i.rd(12'h004, rdat, resp);
    chk("unmapped rresp", 32'h2, {30'h0, resp});
    // Control reset clears drive-ok until the next reset
    speed_raw <= '0;
    ctrl_reset_event <= 1'b1;
    @(posedge aclk);
    ctrl_reset_event <= 1'b0;
    settle();
    rdc(12'h100, exp_st('0, '0, 1'b1, 1'b0, 1'b1));
    rdc(12'h100, exp_st('0, '0, 1'b1, 1'b0, 1'b1));
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    rdc(12'h100, exp_st('0, '0, 1'b0, 1'b1, 1'b1));
    report_and_stop();
  end
endmodule
`default_nettype wire
